// *** rtl/sleep_power_consts.vh ***
// Register offsets, field positions, reset values and timing counts for the sleep controller
`ifndef SLEEP_POWER_CONSTS_VH
`define SLEEP_POWER_CONSTS_VH
`define CORE_CTRL_OFFSET    12'h000
`define POWER_RED_OFFSET    12'h004
`define PWR_STATUS_OFFSET   12'h008
`define CTRL_RESET          8'h00
`define PRR_RESET           8'h00
`define PRR_MASK            8'h0F
`define BIT_BOD_SLEEP       7
`define BIT_SLEEP_ARM       5
`define BIT_MODE_HI         4
`define BIT_MODE_LO         3
`define BIT_BOD_UNLOCK      2
`define BIT_PR_TIMER1       3
`define BIT_PR_TIMER0       2
`define BIT_PR_SERIAL       1
`define BIT_PR_CONV         0
`define MODE_IDLE           2'b00
`define MODE_NOISE          2'b01
`define MODE_POWERDOWN      2'b10
`define MODE_STANDBY        2'b11
`define UNLOCK_WINDOW       3'h4
`define BOD_SLEEP_DELAY     3'h3
`define BOD_SLEEP_HOLD      3'h3
`define CLK_PERIOD_NS       8
`define WAKE_STALL_CYC      16'h0004
`define STANDBY_WAKE_CYC    16'h0006
`define BOD_WAKE_US         60
`define BOD_WAKE_CYC        16'h1D4C // 60 us of 8 ns cycles
`define STARTUP_CYC_DEF     16'h0010
`endif

// *** rtl/sleep_mode_power_controller.v ***
// Sleep mode and power management controller with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "sleep_power_consts.vh"
module sleep_mode_power_controller #(
  parameter [15:0] BOD_WAKE_CYCLES = `BOD_WAKE_CYC,
  parameter [15:0] STARTUP_CYCLES  = `STARTUP_CYC_DEF
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Core handshake
  input  wire        sleepExec,
  input  wire        intPending,
  input  wire        resetRequest,
  output reg         coreStall,
  output reg         takeIntOnWake,
  output reg         resetVectorStart,
  // Asynchronous wake sources
  input  wire        extIntEdge,
  input  wire        timerOverflow,
  input  wire        otherIoInt,
  input  wire        convDoneInt,
  input  wire        storeReadyInt,
  input  wire        levelIntZero,
  input  wire        pinChangeInt,
  input  wire        watchdogInt,
  // Configuration levels
  input  wire        crystalClockSel,
  input  wire        convEnabled,
  input  wire        comparatorEnabled,
  input  wire        comparatorUsesRef,
  input  wire        watchdogEnabled,
  input  wire        brownoutFuseOn,
  // Clock domain and analog controls
  output reg         cpuClkEn,
  output reg         flashClkEn,
  output reg         ioClkEn,
  output reg         convClkEn,
  output reg         oscEn,
  output reg         timerOneClkEn,
  output reg         timerZeroClkEn,
  output reg         serialClkEn,
  output reg         convPeriphClkEn,
  output reg  [3:0]  periphRegBlock,
  output reg         convStartPulse,
  output reg         convExtended,
  output reg         comparatorPowerOn,
  output reg         refEnable,
  output reg         brownoutDetEn,
  output reg         watchdogRun
);

  // Wake counts the start-up time; stall adds the fixed extra cycles
  localparam [2:0] ST_ACTIVE = 3'd0;
  localparam [2:0] ST_SLEEP  = 3'd1;
  localparam [2:0] ST_WAKE   = 3'd2;
  localparam [2:0] ST_STALL  = 3'd3;

  // Wake inputs cross from pins and other clock domains
  reg  [7:0] wakeMeta_r;
  reg  [7:0] wakeSync_r;
  reg  [1:0] rstSync_r;
  always @(posedge core_clk) begin
    if (rst) begin
      wakeMeta_r <= 8'h00;
      wakeSync_r <= 8'h00;
      rstSync_r  <= 2'b00;
    end else begin
      wakeMeta_r <= {extIntEdge, timerOverflow, otherIoInt, convDoneInt,
                     storeReadyInt, levelIntZero, pinChangeInt, watchdogInt};
      wakeSync_r <= wakeMeta_r;
      rstSync_r  <= {rstSync_r[0], resetRequest};
    end
  end
  wire sExtEdge  = wakeSync_r[7];
  wire sTimerOvf = wakeSync_r[6];
  wire sOtherIo  = wakeSync_r[5];
  wire sConvDone = wakeSync_r[4];
  wire sStoreRdy = wakeSync_r[3];
  wire sLevelInt = wakeSync_r[2];
  wire sPinChg   = wakeSync_r[1];
  wire sWdogInt  = wakeSync_r[0];
  wire sReset    = rstSync_r[1];

  // Software-visible state and timers
  reg  [7:0]  ctrl_r;
  reg  [7:0]  prr_r;
  reg         bodSleep_r;
  reg  [2:0]  unlockCnt_r;
  reg  [2:0]  bodArmCnt_r;
  reg  [2:0]  bodHoldCnt_r;
  reg  [2:0]  state_r;
  reg  [1:0]  mode_r;
  reg         bodWasOff_r;
  reg  [15:0] waitCnt_r;
  reg         wakeByInt_r;
  reg         convWasOn_r;
  reg         convExtPend_r;

  // Writes land in the access cycle; the bus never waits
  wire       apbWrite  = psel & penable & pwrite;
  wire       wrCtrl    = apbWrite & (paddr == `CORE_CTRL_OFFSET);
  wire       wrPrr     = apbWrite & (paddr == `POWER_RED_OFFSET);
  wire       unlockHit = wrCtrl & pwdata[`BIT_BOD_SLEEP] & pwdata[`BIT_BOD_UNLOCK];
  wire       bodSetHit = wrCtrl & pwdata[`BIT_BOD_SLEEP] & ~pwdata[`BIT_BOD_UNLOCK]
                         & (unlockCnt_r != 3'h0);
  wire [1:0] modeSel   = ctrl_r[`BIT_MODE_HI:`BIT_MODE_LO];
  wire       deepMode  = (mode_r == `MODE_POWERDOWN) | (mode_r == `MODE_STANDBY);

  // Control registers and timed brown-out disable sequence
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_r       <= `CTRL_RESET;
      prr_r        <= `PRR_RESET;
      bodSleep_r   <= 1'b0;
      unlockCnt_r  <= 3'h0;
      bodArmCnt_r  <= 3'h0;
      bodHoldCnt_r <= 3'h0;
    end else begin
      // Disable and unlock bits are never stored directly
      if (wrCtrl)
        ctrl_r <= {1'b0, pwdata[6:3], 1'b0, pwdata[1:0]};
      if (wrPrr)
        prr_r <= pwdata[7:0] & `PRR_MASK;

      // Unlock opens a short window; only a second write inside it arms the bit
      if (unlockHit)
        unlockCnt_r <= `UNLOCK_WINDOW;
      else if (unlockCnt_r != 3'h0)
        unlockCnt_r <= unlockCnt_r - 3'h1;
      if (bodSetHit)
        bodArmCnt_r <= `BOD_SLEEP_DELAY;
      else if (bodArmCnt_r != 3'h0)
        bodArmCnt_r <= bodArmCnt_r - 3'h1;

      // Bit goes live after the arm delay and drops after the hold time
      if (bodArmCnt_r == 3'h1) begin
        bodSleep_r   <= 1'b1;
        bodHoldCnt_r <= `BOD_SLEEP_HOLD;
      end else if (bodHoldCnt_r == 3'h1) begin
        bodSleep_r   <= 1'b0;
        bodHoldCnt_r <= 3'h0;
      end else if (bodHoldCnt_r != 3'h0) begin
        bodHoldCnt_r <= bodHoldCnt_r - 3'h1;
      end
    end
  end

  // Qualified wake for the mode held in sleep
  // Standby shares the power-down wake set; the oscillator only shortens start-up
  reg wakeQual;
  always @* begin
    case (mode_r)
      `MODE_IDLE:  wakeQual = sExtEdge | sTimerOvf | sOtherIo | sConvDone | sStoreRdy
                              | sLevelInt | sPinChg | sWdogInt;
      `MODE_NOISE: wakeQual = sConvDone | sStoreRdy | sLevelInt | sPinChg
                              | sWdogInt;
      default:     wakeQual = sLevelInt | sPinChg | sWdogInt;
    endcase
  end

  // Sleep sequencer
  reg        sleepGo;
  reg [15:0] wakeLen;
  always @* begin
    sleepGo = sleepExec & ctrl_r[`BIT_SLEEP_ARM];
    // Brown-out restart dominates so the detector settles before code runs
    if (bodWasOff_r)
      wakeLen = BOD_WAKE_CYCLES;
    else if (mode_r == `MODE_STANDBY)
      wakeLen = `STANDBY_WAKE_CYC;
    else if (mode_r == `MODE_POWERDOWN)
      wakeLen = STARTUP_CYCLES;
    else
      wakeLen = 16'h0001;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_r     <= ST_ACTIVE;
      mode_r      <= `MODE_IDLE;
      bodWasOff_r <= 1'b0;
      waitCnt_r   <= 16'h0000;
      wakeByInt_r <= 1'b0;
    end else if (sReset && state_r != ST_ACTIVE) begin
      // A reset wake skips the stall and the interrupt hand-off
      state_r     <= ST_ACTIVE;
      bodWasOff_r <= 1'b0;
      wakeByInt_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ACTIVE: begin
          if (sleepGo) begin
            state_r <= ST_SLEEP;
            // Standby only with a crystal; otherwise fall back to power-down
            if (modeSel == `MODE_STANDBY && !crystalClockSel)
              mode_r <= `MODE_POWERDOWN;
            else
              mode_r <= modeSel;
            bodWasOff_r <= bodSleep_r & modeSel[1];
            wakeByInt_r <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (wakeQual && intPending) begin
            state_r     <= ST_WAKE;
            waitCnt_r   <= wakeLen;
            wakeByInt_r <= 1'b1;
          end
        end
        ST_WAKE: begin
          // Start-up count first, then the fixed stall
          if (waitCnt_r <= 16'h0001) begin
            state_r   <= ST_STALL;
            waitCnt_r <= `WAKE_STALL_CYC;
          end else begin
            waitCnt_r <= waitCnt_r - 16'h0001;
          end
        end
        ST_STALL: begin
          // Clocks already run here; only the core is held
          if (waitCnt_r <= 16'h0001) begin
            state_r     <= ST_ACTIVE;
            bodWasOff_r <= 1'b0;
          end else begin
            waitCnt_r <= waitCnt_r - 16'h0001;
          end
        end
        default: state_r <= ST_ACTIVE;
      endcase
    end
  end

  // Clock gating and analog control outputs
  wire sleeping = (state_r == ST_SLEEP);
  wire asleepOrWake = sleeping | (state_r == ST_WAKE);
  always @(posedge core_clk) begin
    if (rst) begin
      // Every clock runs out of reset
      cpuClkEn          <= 1'b1;
      flashClkEn        <= 1'b1;
      ioClkEn           <= 1'b1;
      convClkEn         <= 1'b1;
      oscEn             <= 1'b1;
      timerOneClkEn     <= 1'b1;
      timerZeroClkEn    <= 1'b1;
      serialClkEn       <= 1'b1;
      convPeriphClkEn   <= 1'b1;
      periphRegBlock    <= 4'h0;
      convStartPulse    <= 1'b0;
      convExtended      <= 1'b0;
      comparatorPowerOn <= 1'b0;
      refEnable         <= 1'b0;
      brownoutDetEn     <= 1'b0;
      watchdogRun       <= 1'b0;
      coreStall         <= 1'b0;
      takeIntOnWake     <= 1'b0;
      resetVectorStart  <= 1'b0;
      convWasOn_r       <= 1'b0;
      convExtPend_r     <= 1'b0;
    end else begin
      // Core stays frozen, not reset, so its registers and memory hold
      cpuClkEn   <= ~(asleepOrWake | sleepGo);
      flashClkEn <= ~(asleepOrWake | sleepGo);
      ioClkEn    <= ~(asleepOrWake & mode_r != `MODE_IDLE);
      convClkEn  <= ~(asleepOrWake & deepMode);
      oscEn      <= ~(asleepOrWake & mode_r == `MODE_POWERDOWN);

      // Peripheral gating only bites while the I/O clock runs
      timerOneClkEn   <= ~prr_r[`BIT_PR_TIMER1];
      timerZeroClkEn  <= ~prr_r[`BIT_PR_TIMER0];
      serialClkEn     <= ~prr_r[`BIT_PR_SERIAL];
      convPeriphClkEn <= ~prr_r[`BIT_PR_CONV];
      periphRegBlock  <= prr_r[3:0];

      // Conversion launch and the extended-conversion flag
      convStartPulse  <= convEnabled & state_r == ST_ACTIVE & sleepGo
                         & ~modeSel[1];
      convWasOn_r <= convEnabled;
      if (convEnabled & ~convWasOn_r)
        convExtPend_r <= 1'b1;
      else if (convStartPulse)
        convExtPend_r <= 1'b0;
      convExtended <= convExtPend_r | (convEnabled & ~convWasOn_r);

      // Deep sleep always powers the comparator down; a reference it uses stays up
      comparatorPowerOn <= comparatorEnabled
                           & ~(asleepOrWake & deepMode);
      brownoutDetEn <= brownoutFuseOn & ~(sleeping & bodWasOff_r);
      refEnable <= (brownoutFuseOn & ~(sleeping & bodWasOff_r))
                   | (comparatorEnabled & (comparatorUsesRef | ~(asleepOrWake & deepMode)))
                   | convEnabled;

      // Watchdog and core handshake
      watchdogRun      <= watchdogEnabled;
      coreStall        <= asleepOrWake | (state_r == ST_STALL & waitCnt_r > 16'h0001);
      takeIntOnWake    <= state_r == ST_STALL & waitCnt_r <= 16'h0001 & wakeByInt_r;
      resetVectorStart <= sReset & state_r != ST_ACTIVE;
    end
  end

  // APB read side; every access finishes in its first access cycle
  // Unmapped offsets answer with an error and read as zero
  reg [31:0] rdMux;
  reg        addrOk;
  always @* begin
    addrOk = 1'b1;
    case (paddr)
      `CORE_CTRL_OFFSET:  rdMux = {24'h000000, bodSleep_r, ctrl_r[6:0]};
      `POWER_RED_OFFSET:  rdMux = {24'h000000, prr_r};
      `PWR_STATUS_OFFSET: rdMux = {27'h0000000, bodWasOff_r, mode_r, state_r[1:0]};
      default: begin
        rdMux  = 32'h00000000;
        addrOk = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Read data is latched at setup so it stands through the access cycle
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addrOk;
      if (psel & ~penable & ~pwrite)
        prdata <= rdMux;
    end
  end

endmodule
`default_nettype wire

// *** verification/sleep_ctrl_sva.sv ***
// Port checker for the sleep mode power controller
`timescale 1ns/1ps
`default_nettype none
module sleep_ctrl_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Core side
  input wire logic       sleepExec,
  input wire logic       resetRequest,
  input wire logic       coreStall,
  input wire logic       takeIntOnWake,
  input wire logic       resetVectorStart,
  // Configuration
  input wire logic       convEnabled,
  input wire logic       watchdogEnabled,
  // Clock controls
  input wire logic       cpuClkEn,
  input wire logic       ioClkEn,
  input wire logic       convClkEn,
  input wire logic       oscEn,
  input wire logic       timerOneClkEn,
  input wire logic       timerZeroClkEn,
  input wire logic       serialClkEn,
  input wire logic       convPeriphClkEn,
  input wire logic [3:0] periphRegBlock,
  input wire logic       convStartPulse,
  input wire logic       watchdogRun
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_enter; $fell(cpuClkEn); endsequence
  sequence s_stalled; $past(coreStall) && $past(coreStall, 4); endsequence
  sequence s_rstSleep; $rose(resetRequest) && coreStall; endsequence
  property p_arm; s_enter |-> $past(sleepExec); endproperty
  a_arm: assert property (p_arm) else $error("cpu clock stopped without sleep");
  property p_idle; !cpuClkEn && ioClkEn |-> convClkEn && oscEn; endproperty
  a_idle: assert property (p_idle) else $error("idle stopped a running clock");
  property p_down; !oscEn |-> !cpuClkEn && !ioClkEn && !convClkEn; endproperty
  a_down: assert property (p_down) else $error("clock runs with oscillator off");
  property p_wdt; watchdogEnabled [*2] |=> watchdogRun; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog stopped");
  property p_stall; $rose(takeIntOnWake) |-> s_stalled; endproperty
  a_stall: assert property (p_stall) else $error("wake stall too short");
  property p_rst; s_rstSleep |-> ##[1:8] resetVectorStart; endproperty
  a_rst: assert property (p_rst) else $error("reset in sleep not taken");
  // Enables and the block bits load on the same edge; only settled states count
  property p_gate;
    ioClkEn && $past(ioClkEn) && $stable(periphRegBlock) |->
      {timerOneClkEn, timerZeroClkEn, serialClkEn, convPeriphClkEn} == ~periphRegBlock;
  endproperty
  a_gate: assert property (p_gate) else $error("peripheral gate mismatch");
  property p_conv; convStartPulse |-> $past(convEnabled) && convClkEn; endproperty
  a_conv: assert property (p_conv) else $error("conversion launched wrongly");
endmodule
`default_nettype wire

// *** verification/core_model.sv ***
// Processor core model issuing sleep and holding interrupts
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and bench commands
  input  wire logic core_clk,
  input  wire logic doSleep,
  input  wire logic raiseInt,
  // Controller side
  input  wire logic coreStall,
  input  wire logic takeIntOnWake,
  output var  logic sleepExec,
  output var  logic intPending
);
  initial begin
    sleepExec = 1'b0;
    intPending = 1'b0;
  end
  always @(posedge core_clk) begin
    // A stalled core runs no instruction, so it cannot issue sleep
    sleepExec <= doSleep && !coreStall;
    if (takeIntOnWake)
      intPending <= 1'b0;
    else if (raiseInt)
      intPending <= 1'b1;
  end
endmodule
`default_nettype wire

// *** verification/test_sleep_mode_power_controller.sv ***
// Self-checking bench for the sleep mode power controller
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_power_controller;
  logic        core_clk, rst, psel, penable, pwrite, doSleep, raiseInt, resetRequest;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdv;
  logic [7:0]  wk;
  logic [5:0]  cfg;
  logic        sErr, sawConv;
  int          fails, n_tests, cyc, wt;
  wire  [31:0] prdata;
  wire  [4:0]  clks;
  wire  [3:0]  prClk, periphRegBlock;
  wire         pready, pslverr, sleepExec, intPending, coreStall, takeIntOnWake;
  wire         resetVectorStart, convStartPulse, convExtended, comparatorPowerOn;
  wire         refEnable, brownoutDetEn, watchdogRun;
  // Short wake count keeps the run brief
  sleep_mode_power_controller #(.BOD_WAKE_CYCLES(16'h0014), .STARTUP_CYCLES(16'h0010))
    u_sleep_mode_power_controller (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleepExec, .intPending, .resetRequest, .coreStall, .takeIntOnWake, .resetVectorStart,
    .extIntEdge(wk[7]), .timerOverflow(wk[6]), .otherIoInt(wk[5]), .convDoneInt(wk[4]),
    .storeReadyInt(wk[3]), .levelIntZero(wk[2]), .pinChangeInt(wk[1]), .watchdogInt(wk[0]),
    .crystalClockSel(cfg[5]), .convEnabled(cfg[4]), .comparatorEnabled(cfg[3]),
    .comparatorUsesRef(cfg[2]), .watchdogEnabled(cfg[1]), .brownoutFuseOn(cfg[0]),
    .cpuClkEn(clks[4]), .flashClkEn(clks[3]), .ioClkEn(clks[2]), .convClkEn(clks[1]),
    .oscEn(clks[0]), .timerOneClkEn(prClk[3]), .timerZeroClkEn(prClk[2]),
    .serialClkEn(prClk[1]), .convPeriphClkEn(prClk[0]), .periphRegBlock, .convStartPulse,
    .convExtended, .comparatorPowerOn, .refEnable, .brownoutDetEn, .watchdogRun);
  core_model u_core_model (.core_clk, .doSleep, .raiseInt, .coreStall, .takeIntOnWake,
    .sleepExec, .intPending);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (convStartPulse === 1'b1)
      sawConv <= 1'b1;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv = prdata;
    sErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic go;
    doSleep  <= 1'b1;
    raiseInt <= 1'b1;
    @(posedge core_clk);
    doSleep  <= 1'b0;
    raiseInt <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wake(input int b);
    wt = 0;
    wk[b] <= 1'b1;
    while (takeIntOnWake !== 1'b1 && wt < 300) begin
      @(posedge core_clk);
      wt++;
    end
    wk <= 8'h00;
    chk(32'(wt < 300), 32'h1);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdv, 32'h0F);
    chk(32'({prClk, periphRegBlock}), 32'h0F);
    apb(1'b1, 12'h004, 32'h5);
    @(posedge core_clk);
    chk(32'({prClk, periphRegBlock}), 32'hA5);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rdv[30:0], sErr}, 32'h1);
  endtask
  task automatic t_modes;
    logic [4:0] ex [4] = '{5'h07, 5'h03, 5'h00, 5'h01};
    for (int m = 0; m < 4; m++) begin
      sawConv = 1'b0;
      apb(1'b1, 12'h000, 32'h20 | 32'(m << 3));
      go();
      chk(32'(clks), 32'(ex[m]));
      chk(32'(sawConv), 32'(m < 2));
      if (m != 0) begin
        wk[5] <= 1'b1;
        repeat (30) @(posedge core_clk);
        chk(32'(coreStall), 32'h1);
      end
      wake(m == 0 ? 6 : 2);
      if (m == 3)
        chk(32'(wt <= 14), 32'h1);
      chk(32'({clks, coreStall}), 32'h3E);
    end
  endtask
  task automatic t_reset;
    apb(1'b1, 12'h000, 32'h30);
    go();
    resetRequest <= 1'b1;
    wt = 0;
    while (resetVectorStart !== 1'b1 && wt < 20) begin
      @(posedge core_clk);
      wt++;
    end
    resetRequest <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(wt < 20), 32'h1);
    chk(32'({clks, coreStall}), 32'h3E);
  endtask
  task automatic t_bod;
    apb(1'b1, 12'h000, 32'hB4);
    apb(1'b1, 12'h000, 32'hB0);
    @(posedge core_clk);
    go();
    chk(32'(brownoutDetEn), 32'h0);
    wake(2);
    chk(32'(wt > 20), 32'h1);
    chk(32'(brownoutDetEn), 32'h1);
  endtask
  task automatic t_analog;
    cfg <= 6'h2F;
    apb(1'b1, 12'h000, 32'h30);
    go();
    chk(32'({comparatorPowerOn, refEnable}), 32'h1);
    wake(2);
    chk(32'(comparatorPowerOn), 32'h1);
    cfg <= 6'h3F;
    repeat (2) @(posedge core_clk);
    chk(32'(convExtended), 32'h1);
    apb(1'b1, 12'h000, 32'h20);
    go();
    chk(32'(convExtended), 32'h0);
    wake(6);
  endtask
  initial begin
    {psel, penable, pwrite, doSleep, raiseInt, resetRequest, sawConv} = 7'h00;
    rst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    wk = 8'h00;
    cfg = 6'h33;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    apb(1'b1, 12'h000, 32'h10);
    go();
    chk(32'({clks, coreStall}), 32'h3E);
    t_modes();
    t_reset();
    t_bod();
    t_analog();
    results();
  end
endmodule
bind sleep_mode_power_controller sleep_ctrl_sva u_sleep_ctrl_sva (.core_clk, .rst,
  .sleepExec, .resetRequest, .coreStall, .takeIntOnWake, .resetVectorStart, .convEnabled,
  .watchdogEnabled, .cpuClkEn, .ioClkEn, .convClkEn, .oscEn, .timerOneClkEn,
  .timerZeroClkEn, .serialClkEn, .convPeriphClkEn, .periphRegBlock, .convStartPulse,
  .watchdogRun);
`default_nettype wire
